// *** rtl/cof_map.svh ***
`ifndef COF_MAP_SVH
`define COF_MAP_SVH

// ----------------------------------------
// Port count and flag layout
// ----------------------------------------
`define COF_PORTS 26
`define COF_FLAG_RST 26'h0000000
`define COF_PAD_W 6

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define COF_IDX_RXPKT 6'h0e
`define COF_IDX_RXLEN 6'h0f
`define COF_IDX_TXPKT 6'h10
`define COF_IDX_STAT 6'h20
`define COF_IDX_MASK 6'h21

// ----------------------------------------
// Interrupt status and mask layout
// ----------------------------------------
`define COF_EV_W 3
`define COF_EV_RXPKT 0
`define COF_EV_RXLEN 1
`define COF_EV_TXPKT 2
`define COF_EV_RST 3'h0
`define COF_EV_PAD_W 29

// ----------------------------------------
// Bus widths and responses
// ----------------------------------------
`define COF_ADDR_W 8
`define COF_RESP_OKAY 2'h0
`define COF_RESP_SLVERR 2'h2

`endif

// *** rtl/cof_pkg.sv ***
`include "cof_map.svh"

package cof_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [`COF_PORTS-1:0] cof_flags_t;
	typedef logic [`COF_EV_W-1:0] cof_ev_t;

	// Word index of a byte address; low two bits select a byte lane only.
	function automatic logic [5:0] cof_index(input logic [`COF_ADDR_W-1:0] addr);
		cof_index = addr[`COF_ADDR_W-1:2];
	endfunction

endpackage

// *** rtl/cof_flag_bank.sv ***
`timescale 1ns/1ps
`include "cof_map.svh"

module cof_flag_bank
	import cof_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Overflow pulses, one per port.
	input wire cof_flags_t ovf,
	// Clear pulse from a register read.
	input wire logic rd_clr,
	// Sticky flags and event indication.
	output cof_flags_t flags,
	output logic hit
);

	cof_flags_t flags_q;
	cof_flags_t flags_d;

	// A read clears the flags it returned; a pulse in the same cycle still lands, so no event is lost.
	always_comb begin
		flags_d = flags_q | ovf;
		if (rd_clr) begin
			flags_d = ovf;
		end
	end

	// Flag register, zero after reset.
	always_ff @(posedge clk) begin
		if (srst) begin
			flags_q <= `COF_FLAG_RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Outputs.
	assign flags = flags_q;
	assign hit = |ovf;

endmodule

// *** rtl/cof_top.sv ***
`timescale 1ns/1ps
`include "cof_map.svh"

module cof_top
	import cof_pkg::*;
(
	// Clock and reset.
	input wire logic CLK,
	input wire logic SRST,
	// Counter overflow pulses, one bit per port.
	input wire cof_flags_t RX_PKT_OVF,
	input wire cof_flags_t RX_LEN_OVF,
	input wire cof_flags_t TX_PKT_OVF,
	// AXI4-Lite write address channel.
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [`COF_ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic [2:0] S_AXI_AWPROT,
	// AXI4-Lite write data channel.
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	// AXI4-Lite write response channel.
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	// AXI4-Lite read address channel.
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [`COF_ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic [2:0] S_AXI_ARPROT,
	// AXI4-Lite read data channel.
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	// Interrupt.
	output logic IRQ
);

	// ----------------------------------------
	// Flag banks
	// ----------------------------------------
	cof_flags_t rx_flags;
	cof_flags_t len_flags;
	cof_flags_t tx_flags;
	logic rx_hit;
	logic len_hit;
	logic tx_hit;
	logic rd_rx;
	logic rd_len;
	logic rd_tx;
	logic rd_st;
	logic ar_hs;
	logic [5:0] ar_idx;

	// Read-clear strobes fire on the edge that captures the read data.
	assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
	assign ar_idx = cof_index(S_AXI_ARADDR);
	assign rd_rx = ar_hs && (ar_idx == `COF_IDX_RXPKT);
	assign rd_len = ar_hs && (ar_idx == `COF_IDX_RXLEN);
	assign rd_tx = ar_hs && (ar_idx == `COF_IDX_TXPKT);
	assign rd_st = ar_hs && (ar_idx == `COF_IDX_STAT);

	// Receive packet count overflow flags.
	cof_flag_bank u_rx (
		.clk(CLK),
		.srst(SRST),
		.ovf(RX_PKT_OVF),
		.rd_clr(rd_rx),
		.flags(rx_flags),
		.hit(rx_hit)
	);

	// Receive packet length count overflow flags.
	cof_flag_bank u_len (
		.clk(CLK),
		.srst(SRST),
		.ovf(RX_LEN_OVF),
		.rd_clr(rd_len),
		.flags(len_flags),
		.hit(len_hit)
	);

	// Transmit packet count overflow flags, all 26 ports alike.
	cof_flag_bank u_tx (
		.clk(CLK),
		.srst(SRST),
		.ovf(TX_PKT_OVF),
		.rd_clr(rd_tx),
		.flags(tx_flags),
		.hit(tx_hit)
	);

	// ----------------------------------------
	// Bus slave state
	// ----------------------------------------
	logic aw_held_q, aw_held_d;
	logic w_held_q, w_held_d;
	logic [`COF_ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	cof_ev_t st_q, st_d;
	cof_ev_t mask_q, mask_d;
	logic irq_q, irq_d;
	logic do_wr;
	cof_ev_t ev;

	// Counter events for the interrupt status.
	assign ev = {tx_hit, len_hit, rx_hit};

	// Address and data are parked separately so either may arrive first; the write runs once both are in.
	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		mask_d = mask_q;
		do_wr = aw_held_q && w_held_q && !bvalid_q;
		if (S_AXI_AWVALID && awready_q) begin
			aw_held_d = 1'b1;
			awaddr_d = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && wready_q) begin
			w_held_d = 1'b1;
			wdata_d = S_AXI_WDATA;
			wstrb_d = S_AXI_WSTRB;
		end
		if (bvalid_q && S_AXI_BREADY) begin
			bvalid_d = 1'b0;
		end
		if (do_wr) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `COF_RESP_OKAY;
			case (cof_index(awaddr_q))
				`COF_IDX_MASK: begin
					if (wstrb_q[0]) begin
						mask_d = wdata_q[`COF_EV_W-1:0];
					end
				end
				// Flag and status words are read-only; writes are accepted and dropped.
				`COF_IDX_RXPKT, `COF_IDX_RXLEN, `COF_IDX_TXPKT, `COF_IDX_STAT: begin
					bresp_d = `COF_RESP_OKAY;
				end
				default: begin
					bresp_d = `COF_RESP_SLVERR;
				end
			endcase
		end
		awready_d = !aw_held_d && !bvalid_d;
		wready_d = !w_held_d && !bvalid_d;
	end

	// Read channel: one read at a time, data registered on the same edge that takes the address.
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && S_AXI_RREADY) begin
			rvalid_d = 1'b0;
		end
		if (ar_hs) begin
			rvalid_d = 1'b1;
			rresp_d = `COF_RESP_OKAY;
			case (ar_idx)
				`COF_IDX_RXPKT: rdata_d = {{`COF_PAD_W{1'b0}}, rx_flags};
				`COF_IDX_RXLEN: rdata_d = {{`COF_PAD_W{1'b0}}, len_flags};
				`COF_IDX_TXPKT: rdata_d = {{`COF_PAD_W{1'b0}}, tx_flags};
				`COF_IDX_STAT: rdata_d = {{`COF_EV_PAD_W{1'b0}}, st_q};
				`COF_IDX_MASK: rdata_d = {{`COF_EV_PAD_W{1'b0}}, mask_q};
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = `COF_RESP_SLVERR;
				end
			endcase
		end
		arready_d = !rvalid_d;
	end

	// Status is cleared by its own read, but a new event in that cycle survives.
	always_comb begin
		st_d = st_q | ev;
		if (rd_st) begin
			st_d = ev;
		end
		irq_d = |(st_d & mask_d);
	end

	// Registers of the bus slave and the interrupt logic.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `COF_RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `COF_RESP_OKAY;
			st_q <= `COF_EV_RST;
			mask_q <= `COF_EV_RST;
			irq_q <= 1'b0;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			st_q <= st_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
		end
	end

	// Every output comes straight from a flop.
	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY = wready_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;
	assign IRQ = irq_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	property p_rx_set;
		cof_flags_t v;
		(|RX_PKT_OVF, v = RX_PKT_OVF) |=> ((rx_flags & v) == v);
	endproperty
	a_rx_set: assert property (p_rx_set) else $error("Receive packet flag not set.");

	property p_rx_clr;
		(rd_rx && !(|RX_PKT_OVF)) |=> (rx_flags == `COF_FLAG_RST);
	endproperty
	a_rx_clr: assert property (p_rx_clr) else $error("Receive packet flags not cleared by read.");

	property p_len_life;
		(RX_LEN_OVF[3] && !rd_len) ##1 (!rd_len && !(|RX_LEN_OVF)) [*2] |-> len_flags[3];
	endproperty
	a_len_life: assert property (p_len_life) else $error("Receive length flag lost before read.");

	property p_len_clr;
		(rd_len && !(|RX_LEN_OVF)) |=> (len_flags == `COF_FLAG_RST);
	endproperty
	a_len_clr: assert property (p_len_clr) else $error("Receive length flags not cleared by read.");

	property p_tx_clr;
		(rd_tx && !(|TX_PKT_OVF)) |=> (tx_flags == `COF_FLAG_RST);
	endproperty
	a_tx_clr: assert property (p_tx_clr) else $error("Transmit packet flags not cleared by read.");

	property p_rdata;
		cof_flags_t v;
		(rd_tx, v = tx_flags) |=> (S_AXI_RVALID && S_AXI_RDATA == {{`COF_PAD_W{1'b0}}, v});
	endproperty
	a_rdata: assert property (p_rdata) else $error("Read data does not match port flags.");

	property p_reset_zero;
		$past(SRST) |-> (rx_flags == `COF_FLAG_RST && len_flags == `COF_FLAG_RST && tx_flags == `COF_FLAG_RST);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("Flags not zero after reset.");

	property p_tx_high;
		TX_PKT_OVF[25] |=> tx_flags[25];
	endproperty
	a_tx_high: assert property (p_tx_high) else $error("Port 25 transmit flag not set.");

	property p_race;
		(rd_rx && RX_PKT_OVF[0]) |=> rx_flags[0];
	endproperty
	a_race: assert property (p_race) else $error("Overflow lost during clearing read.");

	property p_irq;
		// A status read or a mask write in this cycle may legally drop the interrupt.
		(|(st_q & mask_q) && !rd_st && !do_wr) |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt missing for unmasked status.");

	// Main scenarios.
	c_race: cover property (rd_tx && TX_PKT_OVF[19]);
	c_irq: cover property ($rose(IRQ));
	c_wr: cover property (S_AXI_BVALID && S_AXI_BREADY);
	c_rd: cover property (rd_len ##1 S_AXI_RVALID);

endmodule

// *** sim/cof_top_tb_top.sv ***
`timescale 1ns/1ps

module cof_top_tb_top
	import cof_pkg::*;
;

	// ----------------------------------------
	// Bench signals
	// ----------------------------------------
	logic clk, srst, irq;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	cof_flags_t ovf [3];
	cof_flags_t mdl [3];
	logic [2:0] sts;
	int bad_count, num_checks;

	cof_top i_cof_top (
		.CLK(clk), .SRST(srst),
		.RX_PKT_OVF(ovf[0]), .RX_LEN_OVF(ovf[1]), .TX_PKT_OVF(ovf[2]),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.IRQ(irq)
	);

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	// A 100 ns clock.
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end

	// The tests need well under a thousand cycles, so this only catches a hang.
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		stop_test();
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Byte address of flag word b.
	function automatic logic [7:0] fa(input int b);
		return 8'h38 + 8'(4 * b);
	endfunction

	// Flags sit in the low bits; the rest of the word reads zero.
	function automatic logic [31:0] fw(input cof_flags_t f);
		return {6'h0, f};
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	// Write one word; bready rises only after the first edge so it is set once per step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		awvalid <= 1;
		wvalid <= 1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		do begin
			@(posedge clk);
			if (n == 0) bready <= 1;
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			n++;
		end while (bvalid !== 1'b1);
		bready <= 0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	// Read one word; the data compare can be skipped where the value is open.
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input bit ck);
		arvalid <= 1;
		araddr <= a;
		do begin
			@(posedge clk);
			if (arready) begin
				arvalid <= 0;
				rready <= 1;
			end
		end while (rvalid !== 1'b1);
		rready <= 0;
		if (ck) chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// One-cycle overflow pulse on bank b; the model records it.
	task automatic pulse(input int b, input cof_flags_t m);
		ovf[b] <= m;
		@(posedge clk);
		ovf[b] <= '0;
		@(posedge clk);
		mdl[b] |= m;
		if (m != 0) sts[b] = 1;
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		cof_flags_t m;
		int b;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
		ovf = '{default: '0};
		mdl = '{default: '0};
		sts = 0;
		bad_count = 0;
		num_checks = 0;
		srst = 1;
		void'($urandom(32'h8b094763));
		repeat (20) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		for (b = 0; b < 5; b++) begin
			rd(b < 3 ? fa(b) : 8'h80 + 8'(4 * (b - 3)), 32'h0, 2'h0, 1);
		end
		chk({31'h0, irq}, 32'h0);
		done("reset");
		// Corner ports first, then random masks; odd rounds overflow twice before the read.
		for (int i = 0; i < 12; i++) begin
			b = i % 3;
			m = (i < 3) ? 26'h2080001 : cof_flags_t'($urandom());
			pulse(b, m);
			if (i % 2) pulse(b, cof_flags_t'($urandom()));
			for (int k = 0; k < 3; k++) begin
				rd(fa(k), fw(mdl[k]), 2'h0, 1);
				mdl[k] = '0;
			end
		end
		done("banks");
		// Overflow lands on the clearing read edge and must survive it.
		// The pulse stands only at the address handshake edge, so a lost set cannot be masked by a later one.
		m = cof_flags_t'($urandom()) | 26'h0080001;
		ovf[2] <= m;
		fork
			rd(fa(2), 32'h0, 2'h0, 1);
			begin
				@(posedge clk);
				ovf[2] <= '0;
			end
		join
		rd(fa(2), fw(m), 2'h0, 1);
		rd(fa(2), 32'h0, 2'h0, 1);
		done("coincide");
		rd(8'h80, {29'h0, sts}, 2'h0, 1);
		rd(8'h80, 32'h0, 2'h0, 1);
		wr(8'h84, 32'h2, 4'he, 2'h0);
		rd(8'h84, 32'h0, 2'h0, 1);
		wr(8'h84, 32'hfffffffa, 4'hf, 2'h0);
		rd(8'h84, 32'h2, 2'h0, 1);
		pulse(0, m);
		chk({31'h0, irq}, 32'h0);
		pulse(1, m);
		chk({31'h0, irq}, 32'h1);
		rd(8'h80, 32'h3, 2'h0, 1);
		chk({31'h0, irq}, 32'h0);
		done("irq");
		rd(8'h44, 32'h0, 2'h2, 1);
		wr(8'h44, 32'h1, 4'hf, 2'h2);
		wr(fa(0), 32'hffffffff, 4'hf, 2'h0);
		rd(fa(0), fw(mdl[0]), 2'h0, 1);
		done("bus");
		stop_test();
	end

endmodule
